// ---- core/vfc_ctrl.sv ----
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`default_nettype none
module vfc_ctrl
   import vfc_pkg::*;
(
   input wire logic clk_in, // System clock, 25 MHz
   input wire logic resetn_in, // Async reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in, // Write address
   input wire logic s_axi_awvalid_in, // Write address valid
   output logic s_axi_awready_out, // Write address ready
   input wire logic [DATA_W-1:0] s_axi_wdata_in, // Write data
   input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes
   input wire logic s_axi_wvalid_in, // Write data valid
   output logic s_axi_wready_out, // Write data ready
   output logic [1:0] s_axi_bresp_out, // Write response
   output logic s_axi_bvalid_out, // Write response valid
   input wire logic s_axi_bready_in, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr_in, // Read address
   input wire logic s_axi_arvalid_in, // Read address valid
   output logic s_axi_arready_out, // Read address ready
   output logic [DATA_W-1:0] s_axi_rdata_out, // Read data
   output logic [1:0] s_axi_rresp_out, // Read response
   output logic s_axi_rvalid_out, // Read data valid
   input wire logic s_axi_rready_in, // Read data ready
   input wire logic input_select_pin_in, // High forces input B
   input wire logic [1:0] address_strap_pin_in, // 0 low, 1 high, 2/3 open
   output logic input_b_sel_out, // 1 = input B on all channels
   output logic [5:0] input_type_out, // Per-channel input type pairs
   output logic power_down_out, // Analog power-down
   output logic half_mode_out, // Half cutoff on channels 2/3
   output logic bypass_out, // Filter bypass
   output logic [7:0] cutoff_index_out, // Programmed cutoff code
   output logic [FC_W-1:0] ch1_cutoff_out, // Channel 1 cutoff, 10 kHz
   output logic [FC_W-1:0] ch23_cutoff_out // Channels 2/3 cutoff, 10 kHz
);
   // Decode of a bus address into a configuration register hit
   function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
      is_cfg = (a == ADDR_CUTOFF) || (a == ADDR_INTYPE) ||
         (a == ADDR_MODE);
   endfunction : is_cfg

   // Write channel state
   vfc_wst_t wst_ff, nxt_wst;
   logic aw_have_ff, nxt_aw_have;
   logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
   logic w_have_ff, nxt_w_have;
   logic [7:0] w_data_ff, nxt_w_data;
   logic w_strb0_ff, nxt_w_strb0;
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic wr_fire;

   // Configuration flags
   logic [7:0] cutoff_ff, nxt_cutoff;
   logic [5:0] intype_ff, nxt_intype;
   logic [3:0] mode_ff, nxt_mode;

   // Write path: address and data taken in either order, then applied
   always_comb begin
      nxt_wst = wst_ff;
      nxt_aw_have = aw_have_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_have = w_have_ff;
      nxt_w_data = w_data_ff;
      nxt_w_strb0 = w_strb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_cutoff = cutoff_ff;
      nxt_intype = intype_ff;
      nxt_mode = mode_ff;
      wr_fire = 1'b0;
      if (s_axi_awvalid_in && awready_ff) begin
         nxt_aw_have = 1'b1;
         nxt_aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_ff) begin
         nxt_w_have = 1'b1;
         nxt_w_data = s_axi_wdata_in[7:0];
         nxt_w_strb0 = s_axi_wstrb_in[0];
      end
      unique case (wst_ff)
         WR_IDLE: begin
            if (aw_have_ff && w_have_ff) begin
               wr_fire = 1'b1;
               nxt_aw_have = 1'b0;
               nxt_w_have = 1'b0;
               nxt_bvalid = 1'b1;
               nxt_bresp = is_cfg(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
               nxt_wst = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_in) begin
               nxt_bvalid = 1'b0;
               nxt_wst = WR_IDLE;
            end
         end
      endcase
      // Only the low byte carries flags; strobe 0 gates the update
      if (wr_fire && w_strb0_ff) begin
         unique case (aw_addr_ff)
            ADDR_CUTOFF: nxt_cutoff = w_data_ff;
            ADDR_INTYPE: nxt_intype = w_data_ff[INTYPE_MSB:INTYPE_LSB];
            ADDR_MODE: nxt_mode = w_data_ff[MODE_PD_BIT:MODE_BYP_BIT];
            default: ;
         endcase
      end
      nxt_awready = !nxt_aw_have && (nxt_wst == WR_IDLE);
      nxt_wready = !nxt_w_have && (nxt_wst == WR_IDLE);
   end

   // Readies stay low during reset so no write lands before defaults
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wst_ff <= WR_IDLE;
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_have_ff <= 1'b0;
         w_data_ff <= 8'h00;
         w_strb0_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         cutoff_ff <= CUTOFF_RST;
         intype_ff <= INTYPE_RST;
         mode_ff <= MODE_RST;
      end else begin
         wst_ff <= nxt_wst;
         aw_have_ff <= nxt_aw_have;
         aw_addr_ff <= nxt_aw_addr;
         w_have_ff <= nxt_w_have;
         w_data_ff <= nxt_w_data;
         w_strb0_ff <= nxt_w_strb0;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         cutoff_ff <= nxt_cutoff;
         intype_ff <= nxt_intype;
         mode_ff <= nxt_mode;
      end
   end

   // Strap capture, taken once after reset release
   logic strap_valid_ff, nxt_strap_valid;
   logic [7:0] slave_addr_ff, nxt_slave_addr;

   always_comb begin
      nxt_strap_valid = 1'b1;
      nxt_slave_addr = slave_addr_ff;
      if (!strap_valid_ff) begin
         unique case (address_strap_pin_in)
            STRAP_LOW: nxt_slave_addr = SADDR_LOW;
            STRAP_HIGH: nxt_slave_addr = SADDR_HIGH;
            default: nxt_slave_addr = SADDR_OPEN;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         strap_valid_ff <= 1'b0;
         slave_addr_ff <= SADDR_RST;
      end else begin
         strap_valid_ff <= nxt_strap_valid;
         slave_addr_ff <= nxt_slave_addr;
      end
   end

   // Analog settings, refreshed every clock so the pin needs no bus
   logic inb_ff, nxt_inb;

   always_comb begin
      // Bypass does not enter this term, so selection is unchanged
      nxt_inb = input_select_pin_in || mode_ff[MODE_MUX_BIT-MODE_BYP_BIT];
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         inb_ff <= 1'b0;
      end else begin
         inb_ff <= nxt_inb;
      end
   end

   // Read path: only status is readable; flags are write only
   vfc_rst_t rst_ff, nxt_rst;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;

   always_comb begin
      nxt_rst = rst_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      unique case (rst_ff)
         RD_IDLE: begin
            if (s_axi_arvalid_in && arready_ff) begin
               nxt_rvalid = 1'b1;
               nxt_rst = RD_DATA;
               nxt_rdata = '0;
               if (s_axi_araddr_in == ADDR_STATUS) begin
                  nxt_rdata[7:0] = slave_addr_ff;
                  nxt_rdata[STAT_INB_BIT] = inb_ff;
                  nxt_rdata[STAT_VALID_BIT] = strap_valid_ff;
                  nxt_rresp = RESP_OKAY;
               end else begin
                  nxt_rresp = RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            if (s_axi_rready_in) begin
               nxt_rvalid = 1'b0;
               nxt_rst = RD_IDLE;
            end
         end
      endcase
      nxt_arready = (nxt_rst == RD_IDLE);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_ff <= RD_IDLE;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else begin
         rst_ff <= nxt_rst;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // Cutoff table; half applies only to channels 2 and 3
   vfc_cutoff_lut u_lut (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .cutoff_index_in(cutoff_ff),
      .half_in(mode_ff[MODE_HALF_BIT-MODE_BYP_BIT]),
      .ch1_cutoff_out(ch1_cutoff_out),
      .ch23_cutoff_out(ch23_cutoff_out)
   );

   // Outputs straight from flops
   assign s_axi_awready_out = awready_ff;
   assign s_axi_wready_out = wready_ff;
   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_arready_out = arready_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign input_b_sel_out = inb_ff;
   assign input_type_out = intype_ff;
   assign cutoff_index_out = cutoff_ff;
   assign power_down_out = mode_ff[MODE_PD_BIT-MODE_BYP_BIT];
   assign half_mode_out = mode_ff[MODE_HALF_BIT-MODE_BYP_BIT];
   assign bypass_out = mode_ff[0];

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_cut_write;
      wst_ff == WR_IDLE && aw_have_ff && w_have_ff && w_strb0_ff &&
         aw_addr_ff == ADDR_CUTOFF;
   endsequence
   sequence s_both_taken;
      s_axi_awvalid_in && awready_ff ##[0:8]
         (s_axi_wvalid_in && wready_ff);
   endsequence

   AST_PIN_FORCES_B: assert property (
      input_select_pin_in |=> input_b_sel_out)
      else $error("pin high did not select input B");
   AST_FLAG_PICKS: assert property (
      !input_select_pin_in |=>
         input_b_sel_out == $past(mode_ff[MODE_MUX_BIT-MODE_BYP_BIT]))
      else $error("mux flag not followed with pin low");
   AST_RESET_DEFAULTS: assert property (
      @(posedge clk_in) disable iff (1'b0)
      !resetn_in |=> cutoff_index_out == CUTOFF_RST &&
         input_type_out == INTYPE_RST && !bypass_out &&
         !half_mode_out && !power_down_out && !input_b_sel_out)
      else $error("flags not at defaults after reset");
   AST_CUTOFF_WRITE: assert property (
      s_cut_write |=> cutoff_index_out == $past(w_data_ff))
      else $error("cutoff write not applied");
   AST_WRITE_RESPONDS: assert property (
      s_both_taken |-> ##[1:3] s_axi_bvalid_out)
      else $error("no write response after both channels");
   AST_BYPASS_KEEPS_MUX: assert property (
      bypass_out |=> input_b_sel_out == ($past(input_select_pin_in) ||
         $past(mode_ff[MODE_MUX_BIT-MODE_BYP_BIT])))
      else $error("bypass disturbed input selection");
   AST_STRAP_LOW: assert property (
      (!strap_valid_ff && address_strap_pin_in == STRAP_LOW) |=>
         slave_addr_ff == SADDR_LOW && !slave_addr_ff[0] && strap_valid_ff)
      else $error("strap low address wrong");
   AST_STRAP_HIGH: assert property (
      (!strap_valid_ff && address_strap_pin_in == STRAP_HIGH) |=>
         slave_addr_ff == SADDR_HIGH)
      else $error("strap high address wrong");
   AST_NO_READBACK: assert property (
      (s_axi_arvalid_in && arready_ff && is_cfg(s_axi_araddr_in)) |=>
         s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR)
      else $error("configuration register read back");
endmodule : vfc_ctrl
`default_nettype wire

// ---- core/vfc_cutoff_lut.sv ----
`default_nettype none
module vfc_cutoff_lut
   import vfc_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic resetn_in, // Async reset, active low
   input wire logic [7:0] cutoff_index_in, // Programmed cutoff code
   input wire logic half_in, // Half cutoff on channels 2 and 3
   output logic [FC_W-1:0] ch1_cutoff_out, // Channel 1 cutoff, 10 kHz
   output logic [FC_W-1:0] ch23_cutoff_out // Channels 2/3 cutoff, 10 kHz
);
   // Fixed cutoff table in 10 kHz units; not monotonic at code 128
   localparam int unsigned FC_TBL [256] = '{
      400, 418, 435, 451, 467, 484, 500, 516,
      532, 548, 564, 580, 596, 612, 628, 644,
      658, 674, 689, 705, 720, 736, 751, 767,
      782, 797, 812, 828, 843, 858, 873, 889,
      901, 916, 931, 946, 961, 976, 990, 1005,
      1020, 1035, 1049, 1064, 1079, 1094, 1108, 1122,
      1136, 1151, 1165, 1180, 1194, 1208, 1223, 1237,
      1251, 1265, 1280, 1294, 1308, 1322, 1336, 1351,
      1361, 1375, 1389, 1403, 1417, 1431, 1444, 1458,
      1472, 1485, 1499, 1512, 1526, 1540, 1553, 1567,
      1580, 1594, 1607, 1620, 1634, 1648, 1661, 1674,
      1688, 1701, 1714, 1728, 1742, 1755, 1768, 1781,
      1793, 1806, 1819, 1831, 1844, 1858, 1871, 1884,
      1897, 1910, 1923, 1936, 1949, 1962, 1975, 1988,
      2001, 2013, 2026, 2039, 2052, 2064, 2077, 2090,
      2103, 2115, 2128, 2141, 2154, 2166, 2179, 2192,
      751, 782, 811, 841, 869, 899, 928, 957,
      985, 1014, 1043, 1072, 1100, 1129, 1157, 1185,
      1211, 1239, 1267, 1295, 1322, 1350, 1378, 1405,
      1432, 1460, 1487, 1514, 1541, 1569, 1595, 1622,
      1644, 1671, 1697, 1724, 1751, 1777, 1803, 1830,
      1856, 1882, 1908, 1934, 1960, 1986, 2012, 2038,
      2062, 2088, 2113, 2140, 2165, 2190, 2216, 2241,
      2266, 2292, 2317, 2342, 2367, 2393, 2418, 2443,
      2461, 2486, 2511, 2535, 2560, 2585, 2609, 2634,
      2658, 2682, 2707, 2732, 2756, 2780, 2804, 2828,
      2852, 2876, 2899, 2924, 2948, 2972, 2996, 3021,
      3044, 3066, 3089, 3112, 3136, 3159, 3181, 3204,
      3223, 3245, 3268, 3290, 3317, 3342, 3368, 3393,
      3419, 3444, 3469, 3494, 3520, 3544, 3570, 3596,
      3620, 3645, 3670, 3696, 3720, 3745, 3770, 3796,
      3820, 3844, 3870, 3895, 3921, 3946, 3972, 4000
   };

   logic [FC_W-1:0] ch1_ff;
   logic [FC_W-1:0] ch23_ff;
   logic [FC_W-1:0] nxt_ch1;
   logic [FC_W-1:0] nxt_ch23;

   // Table lookup; channel 1 never halves
   always_comb begin
      nxt_ch1 = FC_W'(FC_TBL[cutoff_index_in]);
      nxt_ch23 = half_in ? (nxt_ch1 >> 1) : nxt_ch1;
   end

   // Register the lookup so outputs come from flops
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ch1_ff <= FC_MIN;
         ch23_ff <= FC_MIN;
      end else begin
         ch1_ff <= nxt_ch1;
         ch23_ff <= nxt_ch23;
      end
   end

   assign ch1_cutoff_out = ch1_ff;
   assign ch23_cutoff_out = ch23_ff;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   AST_HALF_RATIO: assert property (
      half_in |=> ch23_cutoff_out == (ch1_cutoff_out >> 1))
      else $error("half cutoff not half of channel 1");
   AST_STD_EQUAL: assert property (
      !half_in |=> ch23_cutoff_out == ch1_cutoff_out)
      else $error("standard mode channels differ");
   AST_TABLE_ENDS: assert property (
      (cutoff_index_in == CODE_MIN |=> ch1_cutoff_out == FC_MIN) and
      (cutoff_index_in == CODE_MAX |=> ch1_cutoff_out == FC_MAX))
      else $error("table end value wrong");
   AST_TABLE_RESTART: assert property (
      cutoff_index_in == CODE_RESTART |=> ch1_cutoff_out == FC_RESTART)
      else $error("table restart value wrong");
endmodule : vfc_cutoff_lut
`default_nettype wire

// ---- core/vfc_pkg.sv ----
`default_nettype none
package vfc_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FC_W = 12;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CUTOFF = 8'h01;
   localparam logic [7:0] IDX_INTYPE = 8'h02;
   localparam logic [7:0] IDX_MODE = 8'h03;
   localparam logic [7:0] ADDR_CUTOFF = 8'(IDX_CUTOFF * 4);
   localparam logic [7:0] ADDR_INTYPE = 8'(IDX_INTYPE * 4);
   localparam logic [7:0] ADDR_MODE = 8'(IDX_MODE * 4);
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Field positions
   localparam int INTYPE_LSB = 2;
   localparam int INTYPE_MSB = 7;
   localparam int MODE_PD_BIT = 7;
   localparam int MODE_MUX_BIT = 6;
   localparam int MODE_HALF_BIT = 5;
   localparam int MODE_BYP_BIT = 4;
   localparam int STAT_INB_BIT = 8;
   localparam int STAT_VALID_BIT = 9;

   // Reset values
   localparam logic [7:0] CUTOFF_RST = 8'h00;
   localparam logic [5:0] INTYPE_RST = 6'h00;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [7:0] SADDR_RST = 8'h00;

   // Strap codes and the bus addresses they select
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_HIGH = 2'h1;
   localparam logic [7:0] SADDR_LOW = 8'h90;
   localparam logic [7:0] SADDR_HIGH = 8'h92;
   localparam logic [7:0] SADDR_OPEN = 8'h94;

   // Cutoff table anchors, units of 10 kHz
   localparam logic [FC_W-1:0] FC_MIN = 12'h190;
   localparam logic [FC_W-1:0] FC_MAX = 12'hfa0;
   localparam logic [FC_W-1:0] FC_RESTART = 12'h2ef;
   localparam logic [7:0] CODE_MIN = 8'h00;
   localparam logic [7:0] CODE_MAX = 8'hff;
   localparam logic [7:0] CODE_RESTART = 8'h80;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } vfc_wst_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } vfc_rst_t;
endpackage : vfc_pkg
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb
   import vfc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0] CDS [6] = '{8'h00, 8'h0a, 8'h7f, 8'h80, 8'he3,
      8'hff};
   localparam logic [11:0] FCS [6] = '{12'h190, 12'h234, 12'h890, 12'h2ef,
      12'hcda, 12'hfa0};
   localparam logic [7:0] SAS [4] = '{SADDR_LOW, SADDR_HIGH, SADDR_OPEN,
      SADDR_OPEN};

   logic clk = 1'h0;
   logic resetn, sel_pin, inb, pd, half, byp;
   logic [1:0] strap, bresp, rresp;
   logic [7:0] awaddr, araddr, code;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [5:0] intype;
   logic [11:0] fc1, fc23;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] rng = 32'h16;
   logic [1:0] q_b[$];
   logic [33:0] q_r[$];

   always #20 clk = ~clk;

   vfc_ctrl u_dut (
      .clk_in(clk),
      .resetn_in(resetn),
      .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready),
      .input_select_pin_in(sel_pin),
      .address_strap_pin_in(strap),
      .input_b_sel_out(inb),
      .input_type_out(intype),
      .power_down_out(pd),
      .half_mode_out(half),
      .bypass_out(byp),
      .cutoff_index_out(code),
      .ch1_cutoff_out(fc1),
      .ch23_cutoff_out(fc23)
   );

   vfc_host_model u_host (
      .clk_in(clk),
      .awaddr_out(awaddr),
      .awvalid_out(awvalid),
      .awready_in(awready),
      .wdata_out(wdata),
      .wstrb_out(wstrb),
      .wvalid_out(wvalid),
      .wready_in(wready),
      .bvalid_in(bvalid),
      .bready_out(bready),
      .araddr_out(araddr),
      .arvalid_out(arvalid),
      .arready_in(arready),
      .rvalid_in(rvalid),
      .rready_out(rready)
   );

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs

   task automatic print_verdict();
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t bresp %h want %h", $time, g, e);
      end
   endtask : cmp_b

   task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t read %h want %h", $time, g, e);
      end
   endtask : cmp_r

   task automatic cmp_v(input logic [11:0] g, input logic [11:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t output %h want %h", $time, g, e);
      end
   endtask : cmp_v

   // Upper data bits and response lag are random; slave ignores both
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] e);
      logic [31:0] r;
      r = xs();
      q_b.push_back(e);
      u_host.write(a, {r[31:8], d}, {r[7:5], 1'h1}, int'(r[1:0]));
      repeat (2) @(posedge clk);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic [31:0] r;
      r = xs();
      q_r.push_back(e);
      u_host.read(a, int'(r[2:1]));
      #1;
   endtask : rd

   task automatic do_reset(input logic [1:0] s);
      @(posedge clk);
      resetn <= 1'h0;
      strap <= s;
      sel_pin <= 1'h0;
      repeat (20) @(posedge clk);
      resetn <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
   endtask : do_reset

   task automatic chk_out(input logic [7:0] c, input logic [5:0] t,
      input logic [3:0] m);
      cmp_v(12'(code), 12'(c));
      cmp_v(12'(intype), 12'(t));
      cmp_v(12'({pd, half, byp}), 12'({m[3], m[1], m[0]}));
   endtask : chk_out

   // Watcher: each response checked against the oldest note; hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (resetn && bvalid && bready) cmp_b(bresp, q_b.pop_front());
      if (resetn && rvalid && rready) begin
         cmp_r({rresp, rdata}, q_r.pop_front());
      end
      // Ending the run is the last thing this process does
      if (cycles == 4000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      logic [31:0] r;
      resetn = 1'h0;
      sel_pin = 1'h0;
      strap = 2'h0;
      do_reset(2'h0);
      chk_out(CUTOFF_RST, INTYPE_RST, MODE_RST);
      cmp_v(fc1, FC_MIN);
      // Table samples on both sides of the restart point
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CUTOFF, CDS[i], RESP_OKAY);
         cmp_v(12'(code), 12'(CDS[i]));
         cmp_v(fc1, FCS[i]);
         cmp_v(fc23, FCS[i]);
      end
      wr(ADDR_MODE, 8'h20, RESP_OKAY);
      cmp_v(fc1, 12'hfa0);
      cmp_v(fc23, 12'h7d0);
      wr(ADDR_CUTOFF, 8'h0a, RESP_OKAY);
      cmp_v(fc23, 12'h11a);
      // Pin and flag combinations while bypassed
      for (int m = 0; m < 2; m++) begin
         for (int p = 0; p < 2; p++) begin
            wr(ADDR_MODE, {1'h0, 1'(m), 2'h1, 4'h0}, RESP_OKAY);
            @(posedge clk);
            sel_pin <= 1'(p);
            @(posedge clk);
            #1;
            cmp_v(12'(inb), 12'(p | m));
            chk_out(8'h0a, 6'h00, {2'h0 | 2'(m), 2'h1});
         end
      end
      repeat (4) begin
         r = xs();
         wr(ADDR_INTYPE, {r[5:0], 2'h0}, RESP_OKAY);
         cmp_v(12'(intype), 12'(r[5:0]));
      end
      wr(ADDR_MODE, 8'h80, RESP_OKAY);
      chk_out(8'h0a, r[5:0], 4'h8);
      // Refused places leave every setting alone
      wr(8'h14, 8'hff, RESP_SLVERR);
      wr(ADDR_STATUS, 8'hff, RESP_SLVERR);
      // Strobe 0 low: answered OKAY, cutoff must stay as it was
      q_b.push_back(RESP_OKAY);
      u_host.write(ADDR_CUTOFF, 32'h55, 4'he, 0);
      repeat (2) @(posedge clk);
      #1;
      for (int i = 1; i < 4; i++) begin
         rd(8'(i * 4), {RESP_SLVERR, 32'h0});
      end
      chk_out(8'h0a, r[5:0], 4'h8);
      rd(ADDR_STATUS, {RESP_OKAY, 22'h0, 2'h3, SADDR_LOW});
      // Mid-run reset with settings applied, strap each way
      for (int s = 0; s < 4; s++) begin
         do_reset(2'(s));
         chk_out(CUTOFF_RST, INTYPE_RST, MODE_RST);
         cmp_v(12'(inb), 12'h0);
         cmp_v(fc1, FC_MIN);
         rd(ADDR_STATUS, {RESP_OKAY, 22'h0, 2'h2, SAS[s]});
      end
      print_verdict();
   end
endmodule : tb
`default_nettype wire

// ---- verif/vfc_host_model.sv ----
`default_nettype none
module vfc_host_model (
   input wire logic clk_in, // Bus clock
   output logic [7:0] awaddr_out, // AW
   output logic awvalid_out, // AW
   input wire logic awready_in, // AW
   output logic [31:0] wdata_out, // W
   output logic [3:0] wstrb_out, // W
   output logic wvalid_out, // W
   input wire logic wready_in, // W
   input wire logic bvalid_in, // B
   output logic bready_out, // B
   output logic [7:0] araddr_out, // AR
   output logic arvalid_out, // AR
   input wire logic arready_in, // AR
   input wire logic rvalid_in, // R
   output logic rready_out // R
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      awaddr_out = 8'h00;
      awvalid_out = 1'h0;
      wdata_out = 32'h0;
      wstrb_out = 4'h0;
      wvalid_out = 1'h0;
      bready_out = 1'h0;
      araddr_out = 8'h00;
      arvalid_out = 1'h0;
      rready_out = 1'h0;
   end

   // Address and data offered together; a released field shows its
   // inverse so a slave that samples late is caught
   task automatic write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input int lag);
      logic aw_done;
      logic w_done;
      aw_done = 1'h0;
      w_done = 1'h0;
      @(posedge clk_in);
      awaddr_out <= a;
      awvalid_out <= 1'h1;
      wdata_out <= d;
      wstrb_out <= s;
      wvalid_out <= 1'h1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_in);
         if (awvalid_out && awready_in) begin
            aw_done = 1'h1;
            awvalid_out <= 1'h0;
            awaddr_out <= ~a;
         end
         if (wvalid_out && wready_in) begin
            w_done = 1'h1;
            wvalid_out <= 1'h0;
            wdata_out <= ~d;
         end
      end
      // Slow host: response accepted only after lag cycles
      repeat (lag) @(posedge clk_in);
      bready_out <= 1'h1;
      do @(posedge clk_in); while (!bvalid_in);
      bready_out <= 1'h0;
   endtask : write

   // Reads only where a refusal or the status word is wanted
   task automatic read(input logic [7:0] a, input int lag);
      @(posedge clk_in);
      araddr_out <= a;
      arvalid_out <= 1'h1;
      do @(posedge clk_in); while (!arready_in);
      arvalid_out <= 1'h0;
      araddr_out <= ~a;
      repeat (lag) @(posedge clk_in);
      rready_out <= 1'h1;
      do @(posedge clk_in); while (!rvalid_in);
      rready_out <= 1'h0;
   endtask : read
endmodule : vfc_host_model
`default_nettype wire
